// [rtl/cmk_ctrl.v]
/*
 * Key driven menu and display-select controller of a radio clock.
 * Assumes active-high key pins and receiver status pins from outside the
 * clock domain, TEMP_MV and sync flags from logic on CLOCK, an APB master.
 */
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "cmk_defines.vh"
module cmk_ctrl #(
    parameter DEB_CYC   = `CMK_CLK_HZ / 1000 * `CMK_DEB_MS,
    parameter LONG_CYC  = `CMK_CLK_HZ / 1000 * `CMK_LONG_MS,
    parameter AEXIT_CYC = `CMK_CLK_HZ / 1000 * `CMK_AEXIT_MS,
    parameter IDLE_CYC  = `CMK_CLK_HZ / 1000 * `CMK_CALIDLE_MS,
    parameter SEC_CYC   = `CMK_CLK_HZ / 1000 * `CMK_SEC_MS
) (
    input  wire        CLOCK,
    input  wire        RST_B,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    input  wire        KEY_FWD,
    input  wire        KEY_BWD,
    input  wire        KEY_PLUS,
    input  wire        KEY_MINUS,
    input  wire        DCF_PULSE,
    input  wire        DCF_CLEAN,
    input  wire        DCF_MARK,
    input  wire        SYNC_ACT,
    input  wire        SYNCED,
    input  wire [11:0] TEMP_MV,
    output wire [3:0]  DISP_SEL,
    output wire [1:0]  DP_POS,
    output wire [7:0]  TEMP_INT,
    output wire [11:0] CAL_VALUE,
    output wire        MENU_ACTIVE,
    output wire [3:0]  MENU_ITEM,
    output wire        MENU_SUB,
    output wire [3:0]  MENU_SUBIDX,
    output wire        ALARM_TMP_EN,
    output wire        FULL_BRIGHT,
    output wire        RX_LED
);
    localparam IT_DISP = 4'h0, IT_TEMP = 4'h1, IT_ALARM = 4'h2;
    localparam IT_BRT = 4'h3, IT_DCF = 4'h4, IT_CLK = 4'h5, IT_END = 4'h9;
    localparam CAL_NONE = 2'h0, CAL_TRUE = 2'h1, CAL_OFS = 2'h2;
    localparam SS_NOSIG = 2'h0, SS_SRCH = 2'h1, SS_READ = 2'h2;
    localparam SS_DONE = 2'h3;
    localparam D_TIME = 4'h0, D_DATE = 4'h1, D_TEMP = 4'h2, D_DASH = 4'h3;
    localparam D_NOSIG = 4'h4, D_SRCH = 4'h5, D_READ = 4'h6, D_DOT = 4'h7;
    localparam D_MENU = 4'h8, D_CAL = 4'h9;
    localparam M_OFF = 2'h0, M_TIME = 2'h1, M_DATE = 2'h2, M_TD = 2'h3;

    // Pin inputs pass two flip-flops; only the second stage is read.
    wire [6:0] pin_w = {DCF_MARK, DCF_CLEAN, DCF_PULSE,
                        KEY_MINUS, KEY_PLUS, KEY_BWD, KEY_FWD};
    reg  [6:0] s1_r;
    reg  [6:0] s2_r;
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s1_r <= 7'h0;
            s2_r <= 7'h0;
        end else begin
            s1_r <= pin_w;
            s2_r <= s1_r;
        end
    end

    wire [3:0] kp;
    wire [3:0] kl;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_key
            reg [31:0] deb_r;
            reg [31:0] hold_r;
            reg        stab_r;
            reg        prs_r;
            reg        lng_r;
            always @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    deb_r  <= 32'h0;
                    hold_r <= 32'h0;
                    stab_r <= 1'h0;
                    prs_r  <= 1'h0;
                    lng_r  <= 1'h0;
                end else begin
                    prs_r <= 1'h0;
                    lng_r <= 1'h0;
                    if (s2_r[g] != stab_r) begin
                        deb_r <= deb_r + 32'h1;
                        if (deb_r >= DEB_CYC - 1) begin
                            stab_r <= s2_r[g];
                            deb_r  <= 32'h0;
                            prs_r  <= s2_r[g];
                        end
                    end else begin
                        deb_r <= 32'h0;
                    end
                    if (!stab_r) begin
                        hold_r <= 32'h0;
                    end else if (hold_r < LONG_CYC) begin
                        hold_r <= hold_r + 32'h1;
                        lng_r  <= (hold_r == LONG_CYC - 1);
                    end
                end
            end
            assign kp[g] = prs_r;
            assign kl[g] = lng_r;
        end
    endgenerate

    // Input counts millivolts: one mV is a tenth of a degree.
    wire signed [11:0] tmv = TEMP_MV;
    reg  signed [11:0] cal_off_r;
    wire signed [12:0] tten = tmv + cal_off_r;
    wire signed [12:0] trnd = tten[12] ? tten - 13'sh5 : tten + 13'sh5;
    wire signed [12:0] tdeg = trnd / 13'sha;

    reg        menu_r;
    reg [3:0]  item_r;
    reg        sub_r;
    reg [3:0]  sidx_r;
    reg [31:0] ex_r;
    reg [31:0] idle_r;
    reg [1:0]  cal_md_r;
    reg signed [11:0] cal_val_r;
    reg        alarm_r;
    reg        flash_r;
    reg [1:0]  mode_r;
    reg        tempen_r;
    reg [4:0]  sbr_r;
    reg [1:0]  rxm_r;
    reg [3:0]  slen;
    always @* begin
        case (item_r)
            IT_ALARM: slen = 4'h6;
            IT_BRT:   slen = 4'hb;
            IT_DCF:   slen = 4'h9;
            IT_CLK:   slen = 4'h9;
            default:  slen = 4'h0;
        endcase
    end
    wire in_main = menu_r && !sub_r;
    wire on_exit = sub_r && (sidx_r == slen - 4'h1);
    wire dcf_ed  = sub_r && (item_r == IT_DCF);

    wire apb_wr = PSEL && PENABLE && PWRITE;
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            menu_r    <= 1'h0;
            item_r    <= IT_DISP;
            sub_r     <= 1'h0;
            sidx_r    <= 4'h0;
            ex_r      <= 32'h0;
            idle_r    <= 32'h0;
            cal_md_r  <= CAL_NONE;
            cal_val_r <= 12'sh0;
            cal_off_r <= 12'sh0;
            alarm_r   <= 1'h0;
            flash_r   <= 1'h0;
            mode_r    <= `CMK_RST_MODE;
            tempen_r  <= `CMK_RST_TEMPEN;
            sbr_r     <= `CMK_RST_SBR;
            rxm_r     <= `CMK_RST_RXM;
        end else begin
            if (cal_md_r != CAL_NONE) begin
                idle_r <= (kp[2] || kp[3]) ? 32'h0 : idle_r + 32'h1;
                if (kp[2] && cal_val_r < `CMK_CAL_MAX)
                    cal_val_r <= cal_val_r + 12'sh1;
                else if (kp[3] && cal_val_r > `CMK_CAL_MIN)
                    cal_val_r <= cal_val_r - 12'sh1;
                if (idle_r >= IDLE_CYC - 1) begin
                    cal_md_r <= CAL_NONE;
                    cal_off_r <= (cal_md_r == CAL_TRUE) ?
                                 cal_val_r - tmv : cal_val_r;
                end
            end else if (!menu_r) begin
                if (kp[0] || kp[1]) begin
                    menu_r <= 1'h1;
                    item_r <= IT_DISP;
                    sub_r  <= 1'h0;
                end
                if (kp[2])
                    alarm_r <= ~alarm_r;
                if (kp[3])
                    flash_r <= ~flash_r;
            end else begin
                if (in_main && item_r == IT_END) begin
                    ex_r <= ex_r + 32'h1;
                    if (ex_r >= AEXIT_CYC - 1)
                        menu_r <= 1'h0;
                end else begin
                    ex_r <= 32'h0;
                end
                if (kp[0]) begin
                    if (sub_r)
                        sidx_r <= on_exit ? 4'h0 : sidx_r + 4'h1;
                    else if (item_r != IT_END)
                        item_r <= item_r + 4'h1;
                end else if (kp[1]) begin
                    if (sub_r)
                        sidx_r <= (sidx_r == 4'h0) ? slen - 4'h1
                                                  : sidx_r - 4'h1;
                    else if (item_r != IT_DISP)
                        item_r <= item_r - 4'h1;
                end else if (kp[2]) begin
                    if (!sub_r && slen != 4'h0) begin
                        sub_r  <= 1'h1;
                        sidx_r <= 4'h0;
                    end else if (on_exit) begin
                        sub_r <= 1'h0;
                    end else if (in_main && item_r == IT_DISP) begin
                        mode_r <= mode_r + 2'h1;
                    end else if (in_main && item_r == IT_TEMP) begin
                        tempen_r <= 1'h1;
                    end else if (dcf_ed) begin
                        if (sidx_r == 4'h1 && sbr_r < `CMK_SBR_MAX)
                            sbr_r <= sbr_r + 5'h1;
                        if (sidx_r == 4'h3 && rxm_r < `CMK_RXM_MAX)
                            rxm_r <= rxm_r + 2'h1;
                    end
                end else if (kp[3]) begin
                    if (in_main && item_r == IT_DISP) begin
                        mode_r <= mode_r - 2'h1;
                    end else if (in_main && item_r == IT_TEMP) begin
                        tempen_r <= 1'h0;
                    end else if (dcf_ed) begin
                        if (sidx_r == 4'h1 && sbr_r != 5'h0)
                            sbr_r <= sbr_r - 5'h1;
                        if (sidx_r == 4'h3 && rxm_r != 2'h0)
                            rxm_r <= rxm_r - 2'h1;
                    end
                end
                if (in_main && item_r == IT_TEMP && (kl[2] || kl[3])) begin
                    cal_md_r  <= kl[2] ? CAL_TRUE : CAL_OFS;
                    cal_val_r <= kl[2] ? tten[11:0] : cal_off_r;
                    idle_r    <= 32'h0;
                end
            end
            // Bus writes come last so software overrides a key edit.
            if (apb_wr && PADDR == `CMK_A_CTRL) begin
                mode_r   <= PWDATA[`CMK_F_MODE_LO +: 2];
                tempen_r <= PWDATA[`CMK_F_TEMPEN];
            end
            if (apb_wr && PADDR == `CMK_A_CFG) begin
                sbr_r <= PWDATA[`CMK_F_SBR_LO +: 5];
                rxm_r <= PWDATA[`CMK_F_RXM_LO +: 2];
            end
            if (apb_wr && PADDR == `CMK_A_CAL)
                cal_off_r <= PWDATA[11:0];
        end
    end

    reg [31:0] sec_r;
    reg [1:0]  ss_r;
    reg [5:0]  rd_r;
    reg [2:0]  alt_r;
    reg [1:0]  ph_r;
    wire tick = (sec_r >= SEC_CYC - 1);
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            sec_r <= 32'h0;
            ss_r  <= SS_NOSIG;
            rd_r  <= 6'h0;
            alt_r <= 3'h0;
            ph_r  <= 2'h0;
        end else begin
            sec_r <= tick ? 32'h0 : sec_r + 32'h1;
            if (tick) begin
                alt_r <= (alt_r >= `CMK_ALT_S - 3'h1) ? 3'h0 : alt_r + 3'h1;
                if (alt_r >= `CMK_ALT_S - 3'h1)
                    ph_r <= (ph_r == 2'h2 || (ph_r == 2'h1 && !tempen_r))
                            ? 2'h0 : ph_r + 2'h1;
            end
            if (!SYNC_ACT) begin
                ss_r <= SS_NOSIG;
            end else begin
                case (ss_r)
                    SS_NOSIG: if (s2_r[5]) ss_r <= SS_SRCH;
                    SS_SRCH: begin
                        if (!s2_r[5]) begin
                            ss_r <= SS_NOSIG;
                        end else if (s2_r[6]) begin
                            ss_r <= SS_READ;
                            rd_r <= `CMK_READ_S;
                        end
                    end
                    SS_READ: begin
                        if (!s2_r[5])
                            ss_r <= SS_NOSIG;
                        else if (rd_r == 6'h0)
                            ss_r <= SS_DONE;
                        else if (tick)
                            rd_r <= rd_r - 6'h1;
                    end
                    default: ss_r <= SS_DONE;
                endcase
            end
        end
    end

    reg [3:0] dsel;
    reg [3:0] dsel_r;
    reg [1:0] dp_r;
    reg [7:0] tint_r;
    reg       led_r;
    always @* begin
        case (mode_r)
            M_OFF:   dsel = tempen_r ? D_TEMP : D_DASH;
            M_TIME:  dsel = (tempen_r && ph_r != 2'h0) ? D_TEMP : D_TIME;
            M_DATE:  dsel = (tempen_r && ph_r != 2'h0) ? D_TEMP : D_DATE;
            default: dsel = (ph_r == 2'h0) ? D_TIME :
                            (ph_r == 2'h1) ? D_DATE : D_TEMP;
        endcase
        if (cal_md_r != CAL_NONE)
            dsel = D_CAL;
        else if (menu_r)
            dsel = D_MENU;
        else if (SYNC_ACT && ss_r != SS_DONE)
            dsel = (sbr_r == 5'h0) ? D_DOT :
                   (ss_r == SS_NOSIG) ? D_NOSIG :
                   (ss_r == SS_SRCH) ? D_SRCH : D_READ;
    end
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            dsel_r <= D_TIME;
            dp_r   <= 2'h0;
            tint_r <= 8'h0;
            led_r  <= 1'h0;
        end else begin
            dsel_r <= dsel;
            dp_r   <= ss_r;
            tint_r <= tdeg[7:0];
            led_r  <= s2_r[4] && SYNC_ACT &&
                      (rxm_r == 2'h2 || (rxm_r == 2'h1 && !SYNCED));
        end
    end

    // Read data is caught in the setup cycle, so no wait state is needed.
    reg  [31:0] rd_d;
    reg  [31:0] prd_r;
    reg         bad;
    always @* begin
        bad  = 1'h0;
        rd_d = 32'h0;
        case (PADDR)
            `CMK_A_CTRL: rd_d = {29'h0, tempen_r, mode_r};
            `CMK_A_CFG:  rd_d = {22'h0, rxm_r, 3'h0, sbr_r};
            `CMK_A_CAL:  rd_d = {20'h0, cal_off_r};
            `CMK_A_STAT: rd_d = {16'h0, cal_md_r, ss_r, flash_r, alarm_r,
                                 sidx_r, sub_r, menu_r, item_r};
            `CMK_A_TEMP: rd_d = {24'h0, tint_r};
            default:     bad  = 1'h1;
        endcase
    end
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B)
            prd_r <= 32'h0;
        else if (PSEL && !PENABLE)
            prd_r <= rd_d;
    end
    assign PRDATA       = prd_r;
    assign PREADY       = 1'h1;
    assign PSLVERR      = PSEL && PENABLE && bad;
    assign DISP_SEL     = dsel_r;
    assign DP_POS       = dp_r;
    assign TEMP_INT     = tint_r;
    assign CAL_VALUE    = cal_val_r;
    assign MENU_ACTIVE  = menu_r;
    assign MENU_ITEM    = item_r;
    assign MENU_SUB     = sub_r;
    assign MENU_SUBIDX  = sidx_r;
    assign ALARM_TMP_EN = alarm_r;
    assign FULL_BRIGHT  = flash_r;
    assign RX_LED       = led_r;
endmodule

// [rtl/cmk_defines.vh]
/*
 * Constants of the clock menu key controller: register offsets, field
 * positions, reset values and timing figures.
 * Assumes inclusion by its bare name from the controller source.
 */
`ifndef CMK_DEFINES_VH
`define CMK_DEFINES_VH
`define CMK_CLK_HZ      200000000
`define CMK_DEB_MS      10
`define CMK_LONG_MS     1000
`define CMK_AEXIT_MS    2000
`define CMK_CALIDLE_MS  3000
`define CMK_SEC_MS      1000
`define CMK_READ_S      6'h3c
`define CMK_ALT_S       3'h4
`define CMK_A_CTRL      8'h00
`define CMK_A_CFG       8'h04
`define CMK_A_CAL       8'h08
`define CMK_A_STAT      8'h0c
`define CMK_A_TEMP      8'h10
`define CMK_F_MODE_LO   0
`define CMK_F_TEMPEN    2
`define CMK_F_SBR_LO    0
`define CMK_F_RXM_LO    8
`define CMK_RST_MODE    2'h3
`define CMK_RST_TEMPEN  1'h0
`define CMK_RST_SBR     5'h0a
`define CMK_RST_RXM     2'h1
`define CMK_SBR_MAX     5'h19
`define CMK_RXM_MAX     2'h2
`define CMK_CAL_MAX     12'sh3e7
`define CMK_CAL_MIN     12'shc19
`endif

// [tb/cmk_ctrl_sva.sv]
/*
 * Port-level checker of the menu key controller.
 * Assumes the bind below, one clock domain and RST_B active low.
 */
`timescale 1ns/1ps
module cmk_ctrl_chk #(
    parameter AEXIT_CYC = 400000000
) (
    input wire        CLOCK,
    input wire        RST_B,
    input wire        PSEL,
    input wire        PENABLE,
    input wire [7:0]  PADDR,
    input wire        PSLVERR,
    input wire        SYNC_ACT,
    input wire [1:0]  DP_POS,
    input wire [3:0]  DISP_SEL,
    input wire        RX_LED,
    input wire        MENU_ACTIVE,
    input wire [3:0]  MENU_ITEM,
    input wire        MENU_SUB,
    input wire [3:0]  MENU_SUBIDX,
    input wire        ALARM_TMP_EN,
    input wire        FULL_BRIGHT
);
    int exit_cnt_r;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    // A counter, because the exit delay is far beyond any delay range.
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            exit_cnt_r <= 0;
        end else if (MENU_ACTIVE && MENU_ITEM == 4'h9) begin
            exit_cnt_r <= exit_cnt_r + 1;
        end else begin
            exit_cnt_r <= 0;
        end
    end
    a_apb_error: assert property (PSEL && PENABLE && PADDR[1:0] == 2'h0
        |-> PSLVERR == (PADDR > 8'h10)) else $error("bad slave error");
    a_menu_open: assert property ($rose(MENU_ACTIVE) |->
        MENU_ITEM == 4'h0 && !MENU_SUB) else $error("menu opened off item 0");
    a_menu_step: assert property (
        MENU_ACTIVE && $past(MENU_ACTIVE) && $changed(MENU_ITEM)
        |-> MENU_ITEM == $past(MENU_ITEM) + 4'h1
        || MENU_ITEM == $past(MENU_ITEM) - 4'h1) else $error("item jump");
    a_sub_exit: assert property ($fell(MENU_SUB) && MENU_ACTIVE |->
        $past(MENU_SUBIDX) == (MENU_ITEM == 4'h2 ? 4'h5 :
        MENU_ITEM == 4'h3 ? 4'ha : 4'h8)) else $error("sub left early");
    a_alarm_normal: assert property ($changed(ALARM_TMP_EN) |->
        !$past(MENU_ACTIVE)) else $error("alarm toggled in menu");
    a_flash_normal: assert property ($changed(FULL_BRIGHT) |->
        !$past(MENU_ACTIVE)) else $error("flashlight toggled in menu");
    a_sync_idle: assert property ((!SYNC_ACT)[*3] |->
        DP_POS == 2'h0) else $error("sync state without attempt");
    a_sync_order: assert property ($changed(DP_POS) |->
        DP_POS == 2'h0 || DP_POS == $past(DP_POS) + 2'h1)
        else $error("sync state skipped");
    a_sync_text: assert property (DISP_SEL inside {4'h4, 4'h5, 4'h6}
        |-> DISP_SEL[1:0] == DP_POS || DISP_SEL[1:0] == $past(DP_POS))
        else $error("status text mismatch");
    a_rx_idle: assert property ((!SYNC_ACT)[*4] |-> !RX_LED)
        else $error("indicator lit outside sync");
    a_auto_exit: assert property (exit_cnt_r <= AEXIT_CYC + 4)
        else $error("menu end not left");
    c_menu_open: cover property ($rose(MENU_ACTIVE));
    c_sub_open: cover property ($rose(MENU_SUB));
    c_synced: cover property (DP_POS == 2'h3);
endmodule
bind cmk_ctrl cmk_ctrl_chk #(.AEXIT_CYC(AEXIT_CYC)) cmk_ctrl_chk_inst (
    .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PSLVERR(PSLVERR), .SYNC_ACT(SYNC_ACT), .DP_POS(DP_POS),
    .DISP_SEL(DISP_SEL), .RX_LED(RX_LED), .MENU_ACTIVE(MENU_ACTIVE),
    .MENU_ITEM(MENU_ITEM), .MENU_SUB(MENU_SUB), .MENU_SUBIDX(MENU_SUBIDX),
    .ALARM_TMP_EN(ALARM_TMP_EN), .FULL_BRIGHT(FULL_BRIGHT));

// [tb/cmk_key_model.sv]
/*
 * Model of the four push buttons, with contact bounce on every press.
 * Assumes calls to press from a process that runs just after a clock edge.
 */
`timescale 1ns/1ps
module cmk_key_model (
    input  wire  clk,
    output logic key_fwd,
    output logic key_bwd,
    output logic key_plus,
    output logic key_minus
);
    logic [3:0] pins_r = 4'h0;
    assign key_fwd = pins_r[0];
    assign key_bwd = pins_r[1];
    assign key_plus = pins_r[2];
    assign key_minus = pins_r[3];
    task automatic press(input int idx, input int hold);
        // A real contact chatters; the blip is shorter than the filter.
        pins_r[idx] <= 1'b1;
        @(posedge clk) pins_r[idx] <= 1'b0;
        @(posedge clk) pins_r[idx] <= 1'b1;
        repeat (hold) @(posedge clk);
        pins_r[idx] <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
endmodule

// [tb/cmk_ctrl_tb.sv]
/*
 * Self-checking bench of the menu key controller: APB tasks, key presses.
 * Assumes shortened debounce, long-press, exit, idle and second counts.
 */
`timescale 1ns/1ps
module cmk_ctrl_tb;
    localparam AEXIT = 60;
    localparam SEC = 20;
    logic        clk = 1'b0, rst_b = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd_v;
    logic        dcf_pulse = 1'b0, dcf_clean = 1'b0, dcf_mark = 1'b0;
    logic        sync_act = 1'b0, synced = 1'b0, err_v;
    logic [11:0] temp_mv = 12'hf15;
    wire  [31:0] prdata;
    wire         pready, pslverr, kf, kb, kp, km, menu_active, menu_sub;
    wire         alarm_tmp_en, full_bright, rx_led;
    wire  [3:0]  disp_sel, menu_item, menu_subidx;
    wire  [1:0]  dp_pos;
    wire  [7:0]  temp_int;
    wire  [11:0] cal_value;
    logic [31:0] mode_tab [4] = '{32'h0, 32'h4, 32'h1, 32'h2};
    logic [3:0]  disp_tab [4] = '{4'h3, 4'h2, 4'h0, 4'h1};
    int          err_total = 0, compares = 0, i;
    always #2.5 clk = ~clk;
    cmk_ctrl #(.DEB_CYC(4), .LONG_CYC(50), .AEXIT_CYC(AEXIT), .IDLE_CYC(80),
        .SEC_CYC(SEC)) cmk_ctrl_inst (.CLOCK(clk), .RST_B(rst_b),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .KEY_FWD(kf), .KEY_BWD(kb), .KEY_PLUS(kp), .KEY_MINUS(km),
        .DCF_PULSE(dcf_pulse), .DCF_CLEAN(dcf_clean), .DCF_MARK(dcf_mark),
        .SYNC_ACT(sync_act), .SYNCED(synced), .TEMP_MV(temp_mv),
        .DISP_SEL(disp_sel), .DP_POS(dp_pos), .TEMP_INT(temp_int),
        .CAL_VALUE(cal_value), .MENU_ACTIVE(menu_active),
        .MENU_ITEM(menu_item), .MENU_SUB(menu_sub), .MENU_SUBIDX(menu_subidx),
        .ALARM_TMP_EN(alarm_tmp_en), .FULL_BRIGHT(full_bright),
        .RX_LED(rx_led));
    cmk_key_model cmk_key_model_inst (.clk(clk), .key_fwd(kf), .key_bwd(kb),
        .key_plus(kp), .key_minus(km));
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        @(posedge clk);
        // Only the watchdog ends a wait for the slave.
        while (pready !== 1'b1) @(posedge clk);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so back-to-back calls never drive psel twice at once.
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("register read", exp, rd_v);
    endtask
    task automatic key(input int idx, input int hold = 10);
        cmk_key_model_inst.press(idx, hold);
    endtask
    task automatic key_rd(input int idx, input logic [7:0] a,
                          input logic [31:0] exp);
        key(idx);
        rd(a, exp);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        wait_cyc(20000);
        err_total++;
        summarize();
    end
    initial begin
        wait_cyc(10);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(8'h00, 32'h3);
        rd(8'h04, 32'h10a);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 32'h1, err_v);
        chk("unmapped data", 32'h0, rd_v);
        chk("temperature", 32'he8, temp_int);
        rd(8'h10, 32'he8);
        apb(1'b1, 8'h08, 32'hf);
        wait_cyc(4);
        chk("temperature", 32'hea, temp_int);
        key(2);
        chk("alarm", 32'h1, alarm_tmp_en);
        key(2);
        chk("alarm", 32'h0, alarm_tmp_en);
        key(3);
        chk("flashlight", 32'h1, full_bright);
        key(3);
        chk("flashlight", 32'h0, full_bright);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, mode_tab[i]);
            wait_cyc(4);
            chk("display select", disp_tab[i], disp_sel);
        end
        key(0);
        chk("menu open", 32'h1, menu_active);
        chk("menu item", 32'h0, menu_item);
        key_rd(2, 8'h00, 32'h3);
        key_rd(2, 8'h00, 32'h0);
        key_rd(3, 8'h00, 32'h3);
        key(0);
        key_rd(2, 8'h00, 32'h7);
        key_rd(3, 8'h00, 32'h3);
        key(1);
        chk("menu item", 32'h0, menu_item);
        for (i = 0; i < 4; i++) key(0);
        key(2);
        chk("submenu", 32'h1, menu_sub);
        chk("sub index", 32'h0, menu_subidx);
        rd(8'h0c, 32'h34);
        key(0);
        key_rd(2, 8'h04, 32'h10b);
        key(3);
        key_rd(3, 8'h04, 32'h109);
        key(0);
        key(0);
        key_rd(2, 8'h04, 32'h209);
        key_rd(3, 8'h04, 32'h109);
        for (i = 0; i < 5; i++) key(0);
        key(2);
        chk("submenu", 32'h0, menu_sub);
        chk("menu item", 32'h4, menu_item);
        for (i = 0; i < 5; i++) key(0);
        wait_cyc(AEXIT + 10);
        chk("menu open", 32'h0, menu_active);
        key(0);
        key(0);
        key(3, 80);
        chk("display select", 32'h9, disp_sel);
        chk("cal value", 32'h00f, cal_value);
        key(2);
        chk("cal value", 32'h010, cal_value);
        wait_cyc(100);
        chk("display select", 32'h8, disp_sel);
        rd(8'h08, 32'h010);
        chk("temperature", 32'hea, temp_int);
        key(2, 80);
        chk("cal value", 32'hf25, cal_value);
        key(3);
        wait_cyc(100);
        rd(8'h08, 32'h00f);
        rst_b <= 1'b0;
        wait_cyc(3);
        rst_b <= 1'b1;
        sync_act <= 1'b1;
        wait_cyc(6);
        chk("display select", 32'h4, disp_sel);
        dcf_clean <= 1'b1;
        wait_cyc(6);
        chk("display select", 32'h5, disp_sel);
        dcf_mark <= 1'b1;
        wait_cyc(4);
        dcf_mark <= 1'b0;
        wait_cyc(6);
        chk("display select", 32'h6, disp_sel);
        wait_cyc(60 * SEC - 60);
        chk("sync state", 32'h2, dp_pos);
        wait_cyc(100);
        chk("sync state", 32'h3, dp_pos);
        // A fresh attempt, since a finished one keeps the normal display.
        sync_act <= 1'b0;
        apb(1'b1, 8'h04, 32'h100);
        sync_act <= 1'b1;
        wait_cyc(6);
        chk("display select", 32'h7, disp_sel);
        dcf_pulse <= 1'b1;
        wait_cyc(6);
        chk("indicator", 32'h1, rx_led);
        synced <= 1'b1;
        wait_cyc(6);
        chk("indicator", 32'h0, rx_led);
        apb(1'b1, 8'h04, 32'h200);
        wait_cyc(6);
        chk("indicator", 32'h1, rx_led);
        apb(1'b1, 8'h04, 32'h0);
        wait_cyc(6);
        chk("indicator", 32'h0, rx_led);
        sync_act <= 1'b0;
        wait_cyc(6);
        chk("sync state", 32'h0, dp_pos);
        summarize();
    end
endmodule
